/* oag_guard_properties.sv */
`timescale 1ns/100ps
module oag_guard_properties
   import oag_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Register bus writes
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   // Array and prefetch
   input wire logic arr_req_i,
   input wire logic arr_we_i,
   input wire logic [15:0] arr_addr_i,
   input wire logic pf_load_i,
   input wire logic [15:0] pf_addr_i,
   // Guard results
   input wire logic arr_grant_o,
   input wire logic arr_done_o,
   input wire logic prog_voltage_en_o,
   input wire logic dev_reset_o,
   input wire logic test_rom_sel_o,
   input wire logic locked_o
);
   logic [7:0] cfg_r;
   logic ext_r;
   logic wr_hs;
   logic norm;
   assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign norm = !test_rom_sel_o;
   // Shadow of the normal config byte and the external-execution flag
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cfg_r <= OAG_CFG_RESET;
         ext_r <= 1'b0;
      end
      else if (wr_hs && s_axi_awaddr == OAG_REG_CFG)
      begin
         cfg_r <= s_axi_wdata[7:0];
      end
      else if (wr_hs && s_axi_awaddr == OAG_REG_CTRL)
      begin
         ext_r <= s_axi_wdata[OAG_CTRL_EXT_EXEC];
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_done_follows_req: assert property (arr_req_i && !locked_o |=> arr_done_o)
      else $error("array cycle not completed");
   a_vpp_only_write: assert property (prog_voltage_en_o |-> arr_done_o &&
      $past(arr_req_i) && $past(arr_we_i))
      else $error("voltage without write");
   a_vpp_lock_off: assert property (arr_req_i && arr_we_i && norm &&
      !(cfg_r[7] && cfg_r[6]) |=> !prog_voltage_en_o)
      else $error("programming under lock");
   a_read_refused: assert property (arr_req_i && !arr_we_i && norm && ext_r &&
      !cfg_r[7] && arr_addr_i >= OAG_PROG_BASE && arr_addr_i <= OAG_ARRAY_END
      |=> !arr_grant_o)
      else $error("protected read granted");
   a_vector_open: assert property (arr_req_i && !arr_we_i && norm &&
      arr_addr_i >= OAG_SPECIAL_BASE && arr_addr_i <= OAG_VEC_LO_END
      |=> arr_grant_o)
      else $error("vector read refused");
   a_pf_reset: assert property (pf_load_i && norm && !cfg_r[7] &&
      (pf_addr_i < OAG_SPECIAL_BASE || pf_addr_i > OAG_ARRAY_END - 16'h0004)
      |=> dev_reset_o)
      else $error("prefetch reset missing");
   a_pf_open: assert property (pf_load_i && cfg_r[7] |=> !dev_reset_o)
      else $error("prefetch reset without lock");
   a_lock_sticky: assert property (locked_o |=> locked_o [*4])
      else $error("lock released");
   a_lock_no_done: assert property (locked_o && arr_req_i |=> !arr_done_o)
      else $error("access while locked");
   a_rom_select: assert property (locked_o |-> test_rom_sel_o)
      else $error("lock outside test rom");
   c_locked: cover property ($rose(locked_o));
   c_pf_reset: cover property (dev_reset_o);
   c_vpp: cover property (prog_voltage_en_o);
endmodule : oag_guard_properties

bind one_time_program_array_access_guard oag_guard_properties u_props (.sys_clk_i(sys_clk_i),
   .rst_b_i(rst_b_i), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .arr_req_i(arr_req_i), .arr_we_i(arr_we_i),
   .arr_addr_i(arr_addr_i), .pf_load_i(pf_load_i), .pf_addr_i(pf_addr_i),
   .arr_grant_o(arr_grant_o), .arr_done_o(arr_done_o),
   .prog_voltage_en_o(prog_voltage_en_o), .dev_reset_o(dev_reset_o),
   .test_rom_sel_o(test_rom_sel_o), .locked_o(locked_o));

/* oag_key_store.sv */
`timescale 1ns/100ps
// Security key words; read data registered
module oag_key_store
   import oag_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Write port
   input wire logic wr_en_i,
   input wire logic [2:0] wr_idx_i,
   input wire logic [15:0] wr_data_i,
   // Read port
   input wire logic [2:0] rd_idx_i,
   output logic [15:0] rd_data_o
);
   typedef struct packed
   {
      logic [OAG_KEY_WORDS-1:0][15:0] mem;
      logic [15:0] rd;
   } oag_key_s;

   oag_key_s st_r;
   oag_key_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (wr_en_i)
      begin
         st_nxt.mem[wr_idx_i] = wr_data_i;
      end
      st_nxt.rd = st_r.mem[rd_idx_i];
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_r <= '{mem: '{default: OAG_KEY_BLANK}, rd: OAG_KEY_BLANK};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign rd_data_o = st_r.rd;
endmodule : oag_key_store

/* oag_pkg.sv */
package oag_pkg;
   // Special-purpose area and program memory
   localparam logic [15:0] OAG_SPECIAL_BASE = 16'h2000;
   localparam logic [15:0] OAG_PROG_BASE = 16'h2080;
   localparam logic [15:0] OAG_VEC_LO_END = 16'h2013;
   localparam logic [15:0] OAG_CFG0_ADDR = 16'h2018;
   localparam logic [15:0] OAG_CFG1_ADDR = 16'h201A;
   localparam logic [15:0] OAG_KEY_BASE = 16'h2020;
   localparam logic [15:0] OAG_KEY_END = 16'h202F;
   localparam logic [15:0] OAG_VEC_HI_BASE = 16'h2030;
   localparam logic [15:0] OAG_VEC_HI_END = 16'h205D;
   localparam logic [15:0] OAG_ARRAY_END = 16'h9FFF;
   localparam logic [15:0] OAG_KEY_BLANK = 16'hFFFF;
   localparam int OAG_KEY_WORDS = 8;
   localparam logic [15:0] OAG_PREFETCH_AHEAD = 16'h0004;
   // Lock bit positions in the configuration byte
   localparam int OAG_READ_LOCK_POS = 7;
   localparam int OAG_WRITE_LOCK_POS = 6;
   localparam logic [7:0] OAG_CFG_RESET = 8'hFF;
   localparam logic [31:0] OAG_AXI_ZERO = 32'h0000_0000;
   // Register byte addresses
   localparam logic [7:0] OAG_REG_CTRL = 8'h00;
   localparam logic [7:0] OAG_REG_STATUS = 8'h04;
   localparam logic [7:0] OAG_REG_CFG = 8'h08;
   localparam logic [7:0] OAG_REG_KEYWR = 8'h0C;
   localparam logic [7:0] OAG_REG_KEYSTAT = 8'h10;
   // Control register fields
   localparam int OAG_CTRL_START = 0;
   localparam int OAG_CTRL_MODE_LO = 1;
   localparam int OAG_CTRL_EXT_EXEC = 4;
   // AXI responses
   localparam logic [1:0] OAG_RESP_OKAY = 2'b00;
   localparam logic [1:0] OAG_RESP_SLVERR = 2'b10;

   typedef enum logic [2:0]
   {
      OAG_MODE_NORMAL = 3'b000,
      OAG_MODE_SLAVE = 3'b001,
      OAG_MODE_AUTO = 3'b010,
      OAG_MODE_SERIAL = 3'b011,
      OAG_MODE_DUMP = 3'b100
   } oag_mode_e;

   typedef enum logic [2:0]
   {
      OAG_ST_NORMAL = 3'b000,
      OAG_ST_CHECK = 3'b001,
      OAG_ST_RUN = 3'b010,
      OAG_ST_REFUSED = 3'b011,
      OAG_ST_LOCKED = 3'b100
   } oag_state_e;
endpackage : oag_pkg

/* oag_prog_model.sv */
`timescale 1ns/100ps
// Programmer side of the array port: one-cycle word requests
module oag_prog_model
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Command from the bench
   input wire logic go_i,
   input wire logic we_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] data_i,
   // Array request
   output logic arr_req_o,
   output logic arr_we_o,
   output logic [15:0] arr_addr_o,
   output logic [15:0] arr_wdata_o
);
   // Released address and data lines toggle so a stale word never looks valid
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         arr_req_o <= 1'b0;
         arr_we_o <= 1'b0;
         arr_addr_o <= 16'h0000;
         arr_wdata_o <= 16'h0000;
      end
      else
      begin
         arr_req_o <= go_i;
         arr_we_o <= go_i && we_i;
         arr_addr_o <= go_i ? addr_i : ~arr_addr_o;
         arr_wdata_o <= go_i ? data_i : ~arr_wdata_o;
      end
   end
endmodule : oag_prog_model

/* one_time_program_array_access_guard.sv */
`timescale 1ns/100ps
// Overview of operation
// - Config register bit 7 read-lock, bit 6 write-lock; one means open.
// - Protected array writes complete the bus cycle but never program.
// - Run-time programming only when both lock bits read one.
// - Read lock plus external execution refuses array reads except vectors, configs.
// - Read lock: external address into prefetch counter forces device reset.
// - Read lock may block the final four bytes of internal memory.
// - Special area 2000h-207Fh: vectors, configs 2018/201A, key 2020-202F.
// - Reset loads normal config bytes; programming entry loads programming ones.
// - Programming entry also copies normal config byte zero to RAM.
// - Programming config bytes writable only in slave mode.
// - Both programming lock bits zero refuses every programming mode.
// - Prog read-lock one, write-lock zero: only dump, with matching key.
// - Dump always compares keys; mismatch locks the device until reset.
// - Slave or auto: compare keys if a normal lock is set.
// - Security key programmable only in slave or auto mode.
// - Slave mode writes key-address program data into the key store as auto mode does, unless a normal lock is set and ext_key_ok is 00h.
// - Serial mode continues only if every key word is FFFFh.
// - Programming modes run the internal test ROM, not user code.
module one_time_program_array_access_guard
   import oag_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Array access from the bus controller
   input wire logic arr_req_i,
   input wire logic arr_we_i,
   input wire logic [15:0] arr_addr_i,
   input wire logic [15:0] arr_wdata_i,
   // Prefetch counter load
   input wire logic pf_load_i,
   input wire logic [15:0] pf_addr_i,
   // Guard results
   output logic arr_grant_o,
   output logic arr_done_o,
   output logic prog_voltage_en_o,
   output logic dev_reset_o,
   output logic test_rom_sel_o,
   output logic [7:0] ram_cfg_copy_o,
   output logic locked_o
);
   typedef struct packed
   {
      oag_state_e state;
      oag_mode_e mode;
      logic ext_exec;
      logic [7:0] cfg_normal;
      logic [7:0] cfg_prog;
      logic [7:0] chip_config_reg_zero;
      logic [7:0] ram_copy;
      logic [3:0] chk_idx;
      logic chk_fail;
      logic [7:0] ext_key_ok;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic grant;
      logic done;
      logic vpp;
      logic dev_rst;
   } oag_s;

   oag_s st_r;
   oag_s st_nxt;
   logic [15:0] key_rd;
   logic key_we;
   logic [2:0] key_widx;
   logic [15:0] key_wdata;

   oag_key_store u_key
   (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .wr_en_i(key_we),
      .wr_idx_i(key_widx),
      .wr_data_i(key_wdata),
      .rd_idx_i(st_r.chk_idx[2:0]),
      .rd_data_o(key_rd)
   );

   function automatic logic is_open_area(input logic [15:0] a);
      is_open_area = (a <= OAG_VEC_LO_END) ||
         (a == OAG_CFG0_ADDR) || (a == OAG_CFG1_ADDR) ||
         (a >= OAG_VEC_HI_BASE && a <= OAG_VEC_HI_END);
   endfunction : is_open_area

   function automatic logic in_array(input logic [15:0] a);
      in_array = (a >= OAG_SPECIAL_BASE) && (a <= OAG_ARRAY_END);
   endfunction : in_array

   logic rd_lock;
   logic wr_lock;
   logic prd;
   logic pwr;
   logic any_lock;
   logic is_key;
   logic [2:0] arr_kidx;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic do_write;
   logic [7:0] wbyte;

   always_comb
   begin
      st_nxt = st_r;
      rd_lock = ~st_r.chip_config_reg_zero[OAG_READ_LOCK_POS];
      wr_lock = ~st_r.chip_config_reg_zero[OAG_WRITE_LOCK_POS];
      prd = st_r.cfg_prog[OAG_READ_LOCK_POS];
      pwr = st_r.cfg_prog[OAG_WRITE_LOCK_POS];
      any_lock = ~st_r.cfg_normal[OAG_READ_LOCK_POS] |
         ~st_r.cfg_normal[OAG_WRITE_LOCK_POS];
      is_key = arr_addr_i >= OAG_KEY_BASE && arr_addr_i <= OAG_KEY_END;
      arr_kidx = arr_addr_i[3:1];
      key_we = 1'b0;
      key_widx = arr_kidx;
      key_wdata = arr_wdata_i;
      aw_hs = s_axi_awvalid && !st_r.aw_got && !st_r.bvalid;
      w_hs = s_axi_wvalid && !st_r.w_got && !st_r.bvalid;
      ar_hs = s_axi_arvalid && !st_r.rvalid;
      do_write = 1'b0;
      wbyte = 8'h00;
      st_nxt.grant = 1'b0;
      st_nxt.done = 1'b0;
      st_nxt.vpp = 1'b0;
      st_nxt.dev_rst = 1'b0;

      // Mode sequencer
      unique case (st_r.state)
         OAG_ST_NORMAL:
         begin
            st_nxt.chip_config_reg_zero = st_r.cfg_normal;
            if (st_r.mode != OAG_MODE_NORMAL)
            begin
               st_nxt.chip_config_reg_zero = st_r.cfg_prog;
               st_nxt.ram_copy = st_r.cfg_normal;
               st_nxt.chk_idx = 4'h0;
               st_nxt.chk_fail = 1'b0;
               if (!prd && !pwr)
                  st_nxt.state = OAG_ST_REFUSED;
               else if (prd && !pwr && st_r.mode != OAG_MODE_DUMP)
                  st_nxt.state = OAG_ST_REFUSED;
               else if ((st_r.mode == OAG_MODE_SLAVE ||
                        st_r.mode == OAG_MODE_AUTO) && !any_lock)
                  st_nxt.state = OAG_ST_RUN;
               else
                  st_nxt.state = OAG_ST_CHECK;
            end
         end
         OAG_ST_CHECK:
         begin
            if (st_r.chk_idx != 4'h0)
            begin
               if (st_r.mode == OAG_MODE_SERIAL)
               begin
                  if (key_rd != OAG_KEY_BLANK)
                     st_nxt.chk_fail = 1'b1;
               end
               else if (!st_r.ext_key_ok[st_r.chk_idx[2:0] - 3'd1])
                  st_nxt.chk_fail = 1'b1;
            end
            if (st_r.chk_idx == 4'(OAG_KEY_WORDS))
               st_nxt.state = (st_nxt.chk_fail) ? OAG_ST_LOCKED : OAG_ST_RUN;
            else
               st_nxt.chk_idx = st_r.chk_idx + 4'h1;
         end
         OAG_ST_RUN, OAG_ST_REFUSED:
         begin
            if (st_r.mode == OAG_MODE_NORMAL)
               st_nxt.state = OAG_ST_NORMAL;
         end
         OAG_ST_LOCKED:
         begin
            st_nxt.state = OAG_ST_LOCKED;
         end
         default:
         begin
            st_nxt.state = OAG_ST_LOCKED;
         end
      endcase

      // Array access guard
      if (arr_req_i && in_array(arr_addr_i) && st_r.state != OAG_ST_LOCKED)
      begin
         st_nxt.done = 1'b1;
         if (!arr_we_i)
         begin
            if (st_r.state == OAG_ST_NORMAL)
               st_nxt.grant = !(rd_lock && st_r.ext_exec &&
                  !is_open_area(arr_addr_i));
            else
               st_nxt.grant = st_r.state == OAG_ST_RUN;
         end
         else if (st_r.state == OAG_ST_NORMAL)
         begin
            if (rd_lock || wr_lock)
               st_nxt.grant = 1'b0;
            else if (is_key && rd_lock)
               st_nxt.grant = 1'b0;
            else
               st_nxt.grant = 1'b1;
            st_nxt.vpp = st_nxt.grant;
         end
         else if (st_r.state == OAG_ST_RUN)
         begin
            if (is_key)
            begin
               if (st_r.mode == OAG_MODE_SLAVE && any_lock &&
                   st_r.chk_fail == 1'b0 && st_r.ext_key_ok == 8'h00)
                  st_nxt.grant = 1'b0;
               else
                  st_nxt.grant = st_r.mode == OAG_MODE_SLAVE ||
                     st_r.mode == OAG_MODE_AUTO;
            end
            else
               st_nxt.grant = st_r.mode != OAG_MODE_DUMP;
            st_nxt.vpp = st_nxt.grant;
            key_we = st_nxt.grant && is_key;
         end
      end

      // Prefetch counter load under read lock
      if (pf_load_i && rd_lock && st_r.state == OAG_ST_NORMAL &&
          (!in_array(pf_addr_i) ||
           pf_addr_i > OAG_ARRAY_END - OAG_PREFETCH_AHEAD))
         st_nxt.dev_rst = 1'b1;

      // AXI4-Lite write side
      if (aw_hs)
      begin
         st_nxt.aw_got = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (w_hs)
      begin
         st_nxt.w_got = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end
      if (st_nxt.aw_got && st_nxt.w_got && !st_r.bvalid)
      begin
         do_write = 1'b1;
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = OAG_RESP_OKAY;
      end
      if (st_r.bvalid && s_axi_bready)
         st_nxt.bvalid = 1'b0;
      if (do_write)
      begin
         wbyte = st_nxt.w_data[7:0];
         unique case (st_nxt.aw_addr)
            OAG_REG_CTRL:
            begin
               if (st_nxt.w_strb[0])
               begin
                  st_nxt.ext_exec = wbyte[OAG_CTRL_EXT_EXEC];
                  if (st_r.state != OAG_ST_LOCKED)
                     st_nxt.mode = oag_mode_e'(
                        wbyte[OAG_CTRL_MODE_LO+:3]);
               end
            end
            OAG_REG_CFG:
            begin
               if (st_nxt.w_strb[0] && st_r.state == OAG_ST_RUN &&
                   st_r.mode != OAG_MODE_DUMP)
                  st_nxt.cfg_normal = wbyte;
               if (st_nxt.w_strb[1] && st_r.state == OAG_ST_RUN &&
                   st_r.mode == OAG_MODE_SLAVE)
                  st_nxt.cfg_prog = st_nxt.w_data[15:8];
            end
            OAG_REG_KEYWR:
            begin
               if (st_r.state == OAG_ST_NORMAL)
                  st_nxt.ext_key_ok = st_nxt.w_data[7:0];
            end
            OAG_REG_STATUS, OAG_REG_KEYSTAT:
            begin
               st_nxt.bresp = OAG_RESP_OKAY;
            end
            default:
            begin
               st_nxt.bresp = OAG_RESP_SLVERR;
            end
         endcase
      end

      // AXI4-Lite read side
      if (st_r.rvalid && s_axi_rready)
         st_nxt.rvalid = 1'b0;
      if (ar_hs)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = OAG_RESP_OKAY;
         st_nxt.rdata = OAG_AXI_ZERO;
         unique case (s_axi_araddr)
            OAG_REG_CTRL:
               st_nxt.rdata[7:0] = {3'b000, st_r.ext_exec, st_r.mode, 1'b0};
            OAG_REG_STATUS:
               st_nxt.rdata[15:0] = {st_r.chip_config_reg_zero,
                  st_r.chk_fail, 4'h0, st_r.state};
            OAG_REG_CFG:
               st_nxt.rdata[15:0] = {st_r.cfg_prog, st_r.cfg_normal};
            OAG_REG_KEYWR:
               st_nxt.rdata[7:0] = st_r.ext_key_ok;
            OAG_REG_KEYSTAT:
               st_nxt.rdata[7:0] = st_r.ram_copy;
            default:
               st_nxt.rresp = OAG_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_r <= '{state: OAG_ST_NORMAL, mode: OAG_MODE_NORMAL,
            cfg_normal: OAG_CFG_RESET, cfg_prog: OAG_CFG_RESET,
            chip_config_reg_zero: OAG_CFG_RESET, ram_copy: OAG_CFG_RESET,
            default: '0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
   assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign arr_grant_o = st_r.grant;
   assign arr_done_o = st_r.done;
   assign prog_voltage_en_o = st_r.vpp;
   assign dev_reset_o = st_r.dev_rst;
   assign test_rom_sel_o = st_r.state != OAG_ST_NORMAL;
   assign ram_cfg_copy_o = st_r.ram_copy;
   assign locked_o = st_r.state == OAG_ST_LOCKED;
endmodule : one_time_program_array_access_guard

/* one_time_program_array_access_guard_tb_top.sv */
`timescale 1ns/100ps
module one_time_program_array_access_guard_tb_top
   import oag_pkg::*;
;
   logic sys_clk_i = 1'b0, rst_b_i = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] bresp, rresp, resp;
   logic go = 1'b0, go_we = 1'b0, pf_load = 1'b0;
   logic [15:0] go_addr = 16'h0, go_data = 16'h0, pf_addr = 16'h0, a;
   logic arr_req, arr_we, grant, done, vpp, dev_rst, rom_sel, locked;
   logic [15:0] arr_addr, arr_wdata;
   logic [7:0] ram_copy;
   logic s_g, s_d, s_v, s_r;
   int failures = 0, comparisons = 0, cycles = 0;
   oag_mode_e modes[4] = '{OAG_MODE_SLAVE, OAG_MODE_AUTO, OAG_MODE_SERIAL,
      OAG_MODE_DUMP};
   logic [7:0] pcfg[3] = '{8'hFF, 8'hBF, 8'h3F};
   logic [7:0] ncfg[4] = '{8'hFF, 8'h7F, 8'hBF, 8'h3F};

   one_time_program_array_access_guard dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .arr_req_i(arr_req),
      .arr_we_i(arr_we), .arr_addr_i(arr_addr), .arr_wdata_i(arr_wdata),
      .pf_load_i(pf_load), .pf_addr_i(pf_addr), .arr_grant_o(grant),
      .arr_done_o(done), .prog_voltage_en_o(vpp), .dev_reset_o(dev_rst),
      .test_rom_sel_o(rom_sel), .ram_cfg_copy_o(ram_copy), .locked_o(locked));
   oag_prog_model u_prog (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .go_i(go), .we_i(go_we), .addr_i(go_addr), .data_i(go_data),
      .arr_req_o(arr_req), .arr_we_o(arr_we), .arr_addr_o(arr_addr),
      .arr_wdata_o(arr_wdata));

   initial
   begin
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic do_reset();
      rst_b_i <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      @(posedge sys_clk_i);
   endtask : do_reset

   task automatic axi_write(input logic [7:0] ad, input logic [31:0] d);
      logic aw_ok, w_ok, b_ok;
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_ok = 1'b0;
      while (!b_ok)
      begin
         @(negedge sys_clk_i);
         aw_ok = awvalid && awready;
         w_ok = wvalid && wready;
         b_ok = bvalid;
         resp = bresp;
         @(posedge sys_clk_i);
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
      end
   endtask : axi_write

   task automatic axi_read(input logic [7:0] ad, output logic [31:0] d);
      logic ar_ok, r_ok;
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_ok = 1'b0;
      while (!r_ok)
      begin
         @(negedge sys_clk_i);
         ar_ok = arvalid && arready;
         r_ok = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge sys_clk_i);
         if (ar_ok) arvalid <= 1'b0;
      end
   endtask : axi_read

   // Config bytes only take writes while programming runs; the programming byte needs slave mode
   task automatic set_cfg(input logic [7:0] p, input logic [7:0] n);
      axi_write(OAG_REG_CTRL, 32'h0000_0002);
      axi_write(OAG_REG_CFG, {16'h0000, p, n});
      axi_write(OAG_REG_CTRL, 32'h0);
   endtask : set_cfg

   task automatic arr_op(input logic we, input logic [15:0] ad);
      go <= 1'b1;
      go_we <= we;
      go_addr <= ad;
      go_data <= 16'($urandom_range(0, 32767));
      @(posedge sys_clk_i);
      go <= 1'b0;
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      {s_g, s_d, s_v} = {grant, done, vpp};
      @(posedge sys_clk_i);
   endtask : arr_op

   task automatic pf_op(input logic [15:0] ad);
      pf_load <= 1'b1;
      pf_addr <= ad;
      @(posedge sys_clk_i);
      pf_load <= 1'b0;
      @(negedge sys_clk_i);
      s_r = dev_rst;
      @(posedge sys_clk_i);
   endtask : pf_op

   function automatic oag_state_e exp_state(logic [7:0] p, logic [7:0] n,
      oag_mode_e m, logic hit, logic blank);
      oag_state_e cmp;
      cmp = hit ? OAG_ST_RUN : OAG_ST_LOCKED;
      if (!p[7] && !p[6])
         return OAG_ST_REFUSED;
      if (!p[6])
         return (m == OAG_MODE_DUMP) ? cmp : OAG_ST_REFUSED;
      if (m == OAG_MODE_SERIAL)
         return blank ? OAG_ST_RUN : OAG_ST_LOCKED;
      if (m == OAG_MODE_DUMP || n[7:6] != 2'b11)
         return cmp;
      return OAG_ST_RUN;
   endfunction : exp_state

   task automatic trial(input logic [7:0] p, input logic [7:0] n,
      input oag_mode_e m, input logic [7:0] fl, input logic blank);
      oag_state_e e;
      int k;
      e = exp_state(p, n, m, fl == 8'hFF, blank);
      set_cfg(p, n);
      axi_write(OAG_REG_KEYWR, {24'h000000, fl});
      axi_write(OAG_REG_CTRL, {28'h0000000, m, 1'b0});
      k = 0;
      do
      begin
         axi_read(OAG_REG_STATUS, rd);
         k++;
      end
      while (rd[2:0] inside {OAG_ST_NORMAL, OAG_ST_CHECK} && k < 40);
      check(rd[2:0], e, "mode state");
      check(rom_sel, 1'b1, "test rom");
      if (e != OAG_ST_REFUSED)
      begin
         check(rd[15:8], p, "active cfg");
         check(ram_copy, n, "ram copy");
      end
      if (e == OAG_ST_LOCKED)
      begin
         arr_op(1'b0, OAG_PROG_BASE);
         check(s_d, 1'b0, "locked access");
         axi_write(OAG_REG_CTRL, 32'h0);
         axi_read(OAG_REG_STATUS, rd);
         check(rd[2:0], OAG_ST_LOCKED, "lock kept");
      end
   endtask : trial

   initial
   begin
      rd = $urandom(32'h4B88);
      do_reset();
      axi_read(OAG_REG_CFG, rd);
      check(rd, 32'h0000_FFFF, "cfg reset");
      axi_read(8'h40, rd);
      check(resp, OAG_RESP_SLVERR, "unmapped");
      for (int i = 0; i < 6; i++)
      begin
         a = 16'($urandom_range(32'h2080, 32'h9FF0));
         arr_op(1'b1, a);
         check({s_d, s_v}, 2'b11, "open write");
         arr_op(1'b0, a);
         check(s_g, 1'b1, "open read");
      end
      for (int j = 1; j < 4; j++)
      begin
         do_reset();
         set_cfg(8'hFF, ncfg[j]);
         axi_write(OAG_REG_CTRL, 32'h0000_0010);
         arr_op(1'b0, OAG_SPECIAL_BASE);
         check(s_g, 1'b1, "vector read");
         arr_op(1'b1, a);
         check({s_d, s_v}, 2'b10, "locked write");
         arr_op(1'b1, OAG_KEY_BASE);
         check(s_v, 1'b0, "key write");
         arr_op(1'b0, a);
         check(s_g, ncfg[j][7], "ext read");
         arr_op(1'b0, OAG_CFG0_ADDR);
         check(s_g, 1'b1, "cfg read");
         pf_op(16'h1000);
         check(s_r, !ncfg[j][7], "pf ext");
         pf_op(16'h9FFE);
         check(s_r, !ncfg[j][7], "pf tail");
      end
      foreach (modes[m])
      begin
         foreach (pcfg[p])
         begin
            do_reset();
            trial(pcfg[p], ncfg[$urandom_range(0, 3)], modes[m],
               $urandom_range(0, 1) ? 8'hFF : 8'($urandom_range(0, 127)), 1'b1);
         end
      end
      do_reset();
      trial(8'hFF, 8'hFF, OAG_MODE_AUTO, 8'hFF, 1'b1);
      arr_op(1'b1, OAG_KEY_BASE + 16'h0002);
      axi_write(OAG_REG_CTRL, 32'h0);
      trial(8'hFF, 8'hFF, OAG_MODE_SERIAL, 8'hFF, 1'b0);
      tally_and_finish();
   end
endmodule : one_time_program_array_access_guard_tb_top
